// *** design/aci_core.sv ***
// Byte command interpreter between a host byte stream and the radio link.
//
// Contract
// - Byte 0x72 answers 'Z' and selects extended 16-bit mode.
// - Extended mode carries values as 16 bits, high byte first.
// - Byte 0x56 replies x,X,y,Y,z,Z: 6 bytes basic, 9 extended.
// - Axis values come straight from the cache of latest radio data.
// - Byte 0x76 adds s+status, t+temperature, b+bandgap to axis reply.
// - Status low two bits are button levels, other bits zero.
// - Byte 0x4B replies X,0g,1g then Y and Z: 9 or 15 bytes.
// - Calibration received at radio connect is kept for queries.
// - Calibration write gives no reply and is forwarded to radio.
// - Legacy F,H,0-3,E commands do not do their old job.
// - Byte 0x47 returns '0' to '3' for the selected range.
// - Byte 0x67 plus '0'-'3' forwards the range, no reply.
// - Byte 0x49 returns version, build and author text.
// - Byte 0x55 turns diagnostic text output on.
// - Byte 0x75 or basic handshake turns diagnostics off.
// - Hex digit before connection forces channel 0-15, latest wins.
// - A forced channel applies only when a connection starts.
// - Forced channel mode is left only by a full reset.
// - Byte 0x51 steps Z, X, Y capture, fourth sends calibration.
// - Byte 0x52 answers 'N' and clears mode, debug and progress.
// - After basic handshake all values are single 8-bit bytes.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ns
module aci_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic link_up,
  input wire logic conn_start,
  input wire logic data_valid,
  input wire aci_pkg::aci_data_s data_pkt,
  input wire logic conn_valid,
  input wire aci_pkg::aci_cal_t conn_cal,
  output logic cal_wr,
  output aci_pkg::aci_cal_t cal_out,
  output logic gsel_wr,
  output logic [1:0] gsel_out,
  output logic chan_force,
  output logic [3:0] chan_num,
  output logic dbg_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata
);

  aci_pkg::aci_state_s s_q;
  aci_pkg::aci_state_s s_d;
  aci_pkg::aci_item_s it;
  aci_pkg::aci_item_s it0;
  logic acc;
  logic tx_done;

  // ==========================================================
  // Helpers.

  // One byte of a value: basic mode sends only the high byte of the left-justified word.
  function automatic logic [7:0] val_byte(input logic [15:0] v, input logic ext,
                                          input logic half);
    val_byte = (ext && half) ? v[7:0] : v[15:8];
  endfunction

  function automatic aci_pkg::aci_item_s mk(input logic is_val, input logic [15:0] v,
                                            input logic last);
    mk.is_val = is_val;
    mk.v = v;
    mk.last = last;
  endfunction

  // Item idx of a reply: either a raw byte or a value of one or two bytes.
  function automatic aci_pkg::aci_item_s get_item(input aci_pkg::aci_kind_e k,
                                                  input logic [3:0] i,
                                                  input aci_pkg::aci_state_s s);
    logic vx;
    vx = (k == aci_pkg::RK_VALX);
    get_item = mk(1'b0, 16'h0000, 1'b1);
    case (k)
      aci_pkg::RK_HS_N: get_item = mk(1'b0, {8'h00, aci_pkg::CH_N}, 1'b1);
      aci_pkg::RK_HS_Z: get_item = mk(1'b0, {8'h00, aci_pkg::CH_Z_UP}, 1'b1);
      aci_pkg::RK_VAL, aci_pkg::RK_VALX: begin
        // Served from the cache so the host never waits on the radio.
        case (i)
          4'h0: get_item = mk(1'b0, {8'h00, aci_pkg::CH_X}, 1'b0);
          4'h1: get_item = mk(1'b1, s.cache.x, 1'b0);
          4'h2: get_item = mk(1'b0, {8'h00, aci_pkg::CH_Y}, 1'b0);
          4'h3: get_item = mk(1'b1, s.cache.y, 1'b0);
          4'h4: get_item = mk(1'b0, {8'h00, aci_pkg::CH_Z}, 1'b0);
          4'h5: get_item = mk(1'b1, s.cache.z, !vx);
          4'h6: get_item = mk(1'b0, {8'h00, aci_pkg::CH_S}, 1'b0);
          4'h7: get_item = mk(1'b0, {14'h0000, s.cache.buttons}, 1'b0);
          4'h8: get_item = mk(1'b0, {8'h00, aci_pkg::CH_T}, 1'b0);
          4'h9: get_item = mk(1'b1, s.cache.temp, 1'b0);
          4'ha: get_item = mk(1'b0, {8'h00, aci_pkg::CH_B}, 1'b0);
          default: get_item = mk(1'b1, s.cache.bgap, 1'b1);
        endcase
      end
      aci_pkg::RK_CAL: begin
        case (i)
          4'h0: get_item = mk(1'b0, {8'h00, aci_pkg::CH_X_UP}, 1'b0);
          4'h3: get_item = mk(1'b0, {8'h00, aci_pkg::CH_Y_UP}, 1'b0);
          4'h6: get_item = mk(1'b0, {8'h00, aci_pkg::CH_Z_UP}, 1'b0);
          4'h1: get_item = mk(1'b1, s.cal[0], 1'b0);
          4'h2: get_item = mk(1'b1, s.cal[1], 1'b0);
          4'h4: get_item = mk(1'b1, s.cal[2], 1'b0);
          4'h5: get_item = mk(1'b1, s.cal[3], 1'b0);
          4'h7: get_item = mk(1'b1, s.cal[4], 1'b0);
          default: get_item = mk(1'b1, s.cal[5], 1'b1);
        endcase
      end
      aci_pkg::RK_GSEL: get_item = mk(1'b0, {8'h00, aci_pkg::CH_0 + {6'h00, s.gsel}}, 1'b1);
      aci_pkg::RK_INFO: begin
        get_item = mk(1'b0, {8'h00, aci_pkg::INFO_TEXT[8*(aci_pkg::INFO_LEN-1-int'(i)) +: 8]},
                      i == 4'(aci_pkg::INFO_LEN - 1));
      end
      default: begin
        // Diagnostic line: 'c' and the channel in use as a hex digit.
        if (i == 4'h0) begin
          get_item = mk(1'b0, {8'h00, aci_pkg::CH_C}, 1'b0);
        end else if (s.ach < 4'(aci_pkg::HEX_A_OFS)) begin
          get_item = mk(1'b0, {8'h00, aci_pkg::CH_0 + {4'h0, s.ach}}, 1'b1);
        end else begin
          get_item = mk(1'b0, {8'h00, aci_pkg::CH_A_UP + {4'h0, s.ach}
                               - aci_pkg::HEX_A_OFS}, 1'b1);
        end
      end
    endcase
  endfunction

  // Start a reply: the first byte is presented in the very next cycle.
  function automatic aci_pkg::aci_state_s start_reply(input aci_pkg::aci_state_s s,
                                                      input aci_pkg::aci_kind_e k);
    aci_pkg::aci_item_s f;
    f = get_item(k, 4'h0, s);
    start_reply = s;
    start_reply.kind = k;
    start_reply.idx = 4'h0;
    start_reply.half = 1'b0;
    start_reply.fsm = aci_pkg::ST_SEND;
    start_reply.txv = 1'b1;
    start_reply.txd = f.is_val ? val_byte(f.v, s.ext, 1'b0) : f.v[7:0];
  endfunction

  function automatic logic is_hex(input logic [7:0] b);
    is_hex = (b >= aci_pkg::CH_0 && b <= aci_pkg::CH_9) ||
             (b >= aci_pkg::CH_A_UP && b <= aci_pkg::CH_F_UP);
  endfunction

  // ==========================================================
  // Next-state logic.
  assign acc = rx_valid && s_q.rxr;
  assign tx_done = s_q.txv && tx_ready;
  assign it = get_item(s_q.kind, s_q.idx, s_q);
  assign it0 = get_item(s_q.kind, s_q.idx + 4'h1, s_q);

  always_comb begin
    s_d = s_q;
    s_d.cwr = 1'b0;
    s_d.gwr = 1'b0;
    s_d.link_d = link_up;

    // Radio side: cache the newest sample and any calibration delivered at connect.
    if (data_valid) begin
      s_d.cache = data_pkt;
      s_d.gsel = data_pkt.grange;
    end
    if (conn_valid) begin
      s_d.cal = conn_cal;
    end
    // The forced choice is copied only at connection start, never mid-link.
    if (conn_start) begin
      s_d.afor = s_q.fen;
      s_d.ach = s_q.fch;
    end
    if (s_q.dbg && link_up && !s_q.link_d) begin
      s_d.dpend = 1'b1;
    end

    // Register port; a write to the status word is ignored.
    if (reg_we && reg_addr == aci_pkg::REG_CTRL) begin
      s_d.en = reg_wdata[aci_pkg::CTRL_EN_BIT];
    end
    s_d.rdata = 32'h0000_0000;
    if (reg_re && reg_addr == aci_pkg::REG_CTRL) begin
      s_d.rdata[aci_pkg::CTRL_EN_BIT] = s_q.en;
    end else if (reg_re && reg_addr == aci_pkg::REG_STAT) begin
      s_d.rdata[16:0] = {s_q.gsel, s_q.stage, s_q.ach, s_q.afor, s_q.fch, s_q.fen,
                         s_q.dbg, s_q.ext, link_up};
    end

    case (s_q.fsm)
      aci_pkg::ST_IDLE: begin
        if (acc && s_q.en) begin
          case (rx_data)
            aci_pkg::CMD_HS_BASIC: begin
              s_d.ext = 1'b0;
              s_d.dbg = 1'b0;
              s_d.stage = 2'h0;
              s_d.dpend = 1'b0;
              s_d = start_reply(s_d, aci_pkg::RK_HS_N);
            end
            aci_pkg::CMD_HS_EXT: begin
              s_d.ext = 1'b1;
              s_d = start_reply(s_d, aci_pkg::RK_HS_Z);
            end
            aci_pkg::CMD_VALUES: s_d = start_reply(s_d, aci_pkg::RK_VAL);
            aci_pkg::CMD_VALUES_EXT: s_d = start_reply(s_d, aci_pkg::RK_VALX);
            aci_pkg::CMD_CAL_READ: s_d = start_reply(s_d, aci_pkg::RK_CAL);
            aci_pkg::CMD_GSEL_READ: s_d = start_reply(s_d, aci_pkg::RK_GSEL);
            aci_pkg::CMD_INFO: s_d = start_reply(s_d, aci_pkg::RK_INFO);
            aci_pkg::CMD_DBG_ON: s_d.dbg = 1'b1;
            aci_pkg::CMD_DBG_OFF: s_d.dbg = 1'b0;
            aci_pkg::CMD_CAL_WRITE: begin
              s_d.acnt = 4'h0;
              s_d.fsm = aci_pkg::ST_ARGK;
            end
            aci_pkg::CMD_GSEL_WRITE: s_d.fsm = aci_pkg::ST_ARGG;
            aci_pkg::CMD_SELF_CAL: begin
              // Z flat gives both zero-g of X and Y, X down gives zero-g of Z.
              case (s_q.stage)
                2'h0: begin
                  s_d.cbuf[0] = s_q.cache.x;
                  s_d.cbuf[2] = s_q.cache.y;
                  s_d.cbuf[5] = s_q.cache.z;
                end
                2'h1: begin
                  s_d.cbuf[1] = s_q.cache.x;
                  s_d.cbuf[4] = s_q.cache.z;
                end
                2'h2: s_d.cbuf[3] = s_q.cache.y;
                default: s_d.cwr = 1'b1;
              endcase
              s_d.stage = s_q.stage + 2'h1;
            end
            default: begin
              // Legacy letters and digits get no old meaning; hex digits pick a channel while the link is down.
              if (is_hex(rx_data) && !link_up) begin
                s_d.fen = 1'b1;
                s_d.fch = (rx_data <= aci_pkg::CH_9) ? 4'(rx_data - aci_pkg::CH_0)
                          : 4'(rx_data - aci_pkg::CH_A_UP + aci_pkg::HEX_A_OFS);
              end
              // Anything else falls through with nothing changed.
            end
          endcase
        end else if (s_q.dpend) begin
          s_d.dpend = 1'b0;
          s_d = start_reply(s_d, aci_pkg::RK_DBG);
        end
      end
      aci_pkg::ST_ARGK: begin
        // Basic bytes sit left-justified; extended pairs arrive high byte first.
        if (acc) begin
          if (!s_q.ext) begin
            s_d.cbuf[s_q.acnt[2:0]] = {rx_data, 8'h00};
          end else if (!s_q.acnt[0]) begin
            s_d.cbuf[s_q.acnt[3:1]][15:8] = rx_data;
          end else begin
            s_d.cbuf[s_q.acnt[3:1]][7:0] = rx_data;
          end
          s_d.acnt = s_q.acnt + 4'h1;
          if (s_q.acnt == (s_q.ext ? aci_pkg::CAL_ARGS_EXT : aci_pkg::CAL_ARGS_BASIC) - 4'h1) begin
            s_d.cwr = 1'b1;
            s_d.fsm = aci_pkg::ST_IDLE;
          end
        end
      end
      aci_pkg::ST_ARGG: begin
        // An argument out of range is swallowed without effect.
        if (acc) begin
          if (rx_data >= aci_pkg::CH_0 && rx_data <= aci_pkg::CH_3) begin
            s_d.gsel = rx_data[1:0];
            s_d.gwr = 1'b1;
          end
          s_d.fsm = aci_pkg::ST_IDLE;
        end
      end
      aci_pkg::ST_SEND: begin
        if (tx_done) begin
          if (it.is_val && s_q.ext && !s_q.half) begin
            s_d.half = 1'b1;
            s_d.txd = val_byte(it.v, 1'b1, 1'b1);
          end else if (it.last) begin
            s_d.txv = 1'b0;
            s_d.fsm = aci_pkg::ST_IDLE;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
            s_d.half = 1'b0;
            s_d.txd = it0.is_val ? val_byte(it0.v, s_q.ext, 1'b0) : it0.v[7:0];
          end
        end
      end
      default: s_d.fsm = aci_pkg::ST_IDLE;
    endcase
    // Input is held off while a reply is going out, so commands never overlap.
    s_d.rxr = (s_d.fsm != aci_pkg::ST_SEND);
  end

  // Synchronous reset; forced channel mode survives everything except this.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.fsm <= aci_pkg::ST_IDLE;
      s_q.en <= 1'b1;
      s_q.rxr <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register.
  assign rx_ready = s_q.rxr;
  assign tx_valid = s_q.txv;
  assign tx_data = s_q.txd;
  assign cal_wr = s_q.cwr;
  assign cal_out = s_q.cbuf;
  assign gsel_wr = s_q.gwr;
  assign gsel_out = s_q.gsel;
  assign chan_force = s_q.afor;
  assign chan_num = s_q.ach;
  assign dbg_en = s_q.dbg;
  assign reg_rdata = s_q.rdata;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic idle_acc;
  assign idle_acc = acc && s_q.en && s_q.fsm == aci_pkg::ST_IDLE;

  chk_ext_handshake: assert property (idle_acc && rx_data == aci_pkg::CMD_HS_EXT |=>
    tx_valid && tx_data == aci_pkg::CH_Z_UP && s_q.ext) else $error("no Z or mode");
  chk_basic_handshake: assert property (idle_acc && rx_data == aci_pkg::CMD_HS_BASIC |=>
    tx_valid && tx_data == aci_pkg::CH_N && !s_q.ext && !dbg_en) else $error("bad N reply");
  chk_values_first: assert property (idle_acc && rx_data == aci_pkg::CMD_VALUES |=>
    tx_valid && tx_data == aci_pkg::CH_X && !rx_ready) else $error("bad V start");
  chk_gsel_reply: assert property (idle_acc && rx_data == aci_pkg::CMD_GSEL_READ |=>
    tx_data == aci_pkg::CH_0 + {6'h00, $past(s_q.gsel)}) else $error("bad G reply");
  chk_cal_silent: assert property (idle_acc && rx_data == aci_pkg::CMD_CAL_WRITE |=>
    !tx_valid && s_q.fsm == aci_pkg::ST_ARGK) else $error("cal write replied");
  chk_debug_off: assert property (idle_acc && rx_data == aci_pkg::CMD_DBG_OFF |=>
    !dbg_en) else $error("debug still on");
  chk_chan_hold: assert property (!conn_start |=> $stable(chan_num) &&
    $stable(chan_force)) else $error("channel moved");
  chk_force_sticky: assert property (s_q.fen |=> s_q.fen) else
    $error("forced mode lost");
  chk_hex_select: assert property (idle_acc && rx_data == aci_pkg::CH_F_UP && !link_up |=>
    s_q.fen && s_q.fch == 4'hf) else $error("channel not forced");
  chk_unknown_drop: assert property (idle_acc && rx_data == 8'h21 |=>
    !tx_valid && $stable(s_q.ext) && $stable(dbg_en)) else $error("unknown byte acted");
  chk_vals_len: assert property (idle_acc && rx_data == aci_pkg::CMD_VALUES && !s_q.ext
    ##1 tx_ready [*6] |=> !tx_valid) else $error("V length wrong");
  chk_debug_on: assert property (idle_acc && rx_data == aci_pkg::CMD_DBG_ON |=>
    dbg_en) else $error("debug not on");
  chk_gsel_fwd: assert property (s_q.fsm == aci_pkg::ST_ARGG && acc &&
    rx_data >= aci_pkg::CH_0 && rx_data <= aci_pkg::CH_3 |=>
    gsel_wr && gsel_out == $past(rx_data[1:0])) else $error("range not forwarded");
  // A stalled host must see the same byte again, or its reply parser slips.
  chk_reply_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("reply byte dropped");

  cov_values_ext: cover property (idle_acc && rx_data == aci_pkg::CMD_VALUES_EXT && s_q.ext);
  cov_cal_write: cover property (cal_wr);
  cov_gsel_write: cover property (gsel_wr);
  cov_debug_line: cover property (s_q.fsm == aci_pkg::ST_SEND && s_q.kind == aci_pkg::RK_DBG);

endmodule

// *** design/aci_pkg.sv ***
// Shared constants and types of the accelerometer command interpreter.
package aci_pkg;

  // ==========================================================
  // Command bytes received from the host.
  localparam logic [7:0] CMD_HS_BASIC = 8'h52;
  localparam logic [7:0] CMD_HS_EXT = 8'h72;
  localparam logic [7:0] CMD_VALUES = 8'h56;
  localparam logic [7:0] CMD_VALUES_EXT = 8'h76;
  localparam logic [7:0] CMD_CAL_READ = 8'h4b;
  localparam logic [7:0] CMD_CAL_WRITE = 8'h6b;
  localparam logic [7:0] CMD_GSEL_READ = 8'h47;
  localparam logic [7:0] CMD_GSEL_WRITE = 8'h67;
  localparam logic [7:0] CMD_INFO = 8'h49;
  localparam logic [7:0] CMD_DBG_ON = 8'h55;
  localparam logic [7:0] CMD_DBG_OFF = 8'h75;
  localparam logic [7:0] CMD_SELF_CAL = 8'h51;

  // ==========================================================
  // Reply characters and character ranges.
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_Z_UP = 8'h5a;
  localparam logic [7:0] CH_X_UP = 8'h58;
  localparam logic [7:0] CH_Y_UP = 8'h59;
  localparam logic [7:0] CH_X = 8'h78;
  localparam logic [7:0] CH_Y = 8'h79;
  localparam logic [7:0] CH_Z = 8'h7a;
  localparam logic [7:0] CH_S = 8'h73;
  localparam logic [7:0] CH_T = 8'h74;
  localparam logic [7:0] CH_B = 8'h62;
  localparam logic [7:0] CH_C = 8'h63;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A_UP = 8'h41;
  localparam logic [7:0] CH_F_UP = 8'h46;
  localparam logic [7:0] HEX_A_OFS = 8'h0a;

  // Identification text; the content is arbitrary.
  localparam int INFO_LEN = 16;
  localparam logic [8*INFO_LEN-1:0] INFO_TEXT = "FW1.0 B0001 RTL\n";

  // Argument byte counts of the calibration write.
  localparam logic [3:0] CAL_ARGS_BASIC = 4'h6;
  localparam logic [3:0] CAL_ARGS_EXT = 4'hc;

  // ==========================================================
  // Register port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CTRL_EN_BIT = 0;

  // ==========================================================
  // Types.
  typedef logic [5:0][15:0] aci_cal_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARGK = 4'b0010,
    ST_ARGG = 4'b0100,
    ST_SEND = 4'b1000
  } aci_fsm_e;

  typedef enum logic [2:0] {
    RK_HS_N, RK_HS_Z, RK_VAL, RK_VALX, RK_CAL, RK_GSEL, RK_INFO, RK_DBG
  } aci_kind_e;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] temp;
    logic [15:0] bgap;
    logic [1:0] buttons;
    logic [1:0] grange;
  } aci_data_s;

  typedef struct packed {
    logic is_val;
    logic [15:0] v;
    logic last;
  } aci_item_s;

  typedef struct packed {
    aci_fsm_e fsm;
    aci_kind_e kind;
    logic [3:0] idx;
    logic half;
    logic ext;
    logic dbg;
    logic en;
    logic fen;
    logic [3:0] fch;
    logic afor;
    logic [3:0] ach;
    logic [1:0] stage;
    logic [1:0] gsel;
    logic [3:0] acnt;
    aci_data_s cache;
    aci_cal_t cal;
    aci_cal_t cbuf;
    logic cwr;
    logic gwr;
    logic dpend;
    logic link_d;
    logic txv;
    logic [7:0] txd;
    logic rxr;
    logic [31:0] rdata;
  } aci_state_s;

endpackage

// *** test/aci_host_model.sv ***
// Host-side sink model that takes reply bytes with random stalls.
`timescale 1ns/1ns
module aci_host_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] lfsr_q = 8'h5b;
  logic [7:0] got[$];
  initial tx_ready = 1'b0;
  // ==========================================================
  // Sink
  // A host that stalls now and then shows that each reply byte is held.
  always @(posedge core_clk) begin
    lfsr_q <= !rst_n ? 8'h5b : {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    tx_ready <= lfsr_q[0] | lfsr_q[1];
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
endmodule

// *** test/tb_aci_core.sv ***
// Self-checking bench of the accelerometer command interpreter.
`timescale 1ns/1ns
module tb_aci_core;
  logic core_clk = 0, rst_n = 0, rx_valid = 0, link_up = 0, conn_start = 0;
  logic data_valid = 0, conn_valid = 0, reg_we = 0, reg_re = 0, tx_ready;
  logic [7:0] rx_data = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  aci_pkg::aci_data_s data_pkt = '0, pkt;
  aci_pkg::aci_cal_t conn_cal = '0, cal_out, cal, kw, ek;
  logic rx_ready, tx_valid, cal_wr, gsel_wr, chan_force, dbg_en;
  logic [7:0] tx_data;
  logic [1:0] gsel_out, d;
  logic [3:0] chan_num;
  int err_total = 0, n_checks = 0, ncal = 0, ngs = 0;
  logic [31:0] rs = 32'h4d7c;
  logic ext = 0;
  logic [7:0] exp[$];
  string leg = "FHE0123";
  always #50 core_clk = ~core_clk;
  // Count forwarding pulses; a pulse longer than one cycle shows up as a miscount.
  always @(posedge core_clk) begin
    ncal <= ncal + int'(cal_wr);
    ngs <= ngs + int'(gsel_wr);
  end
  aci_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .link_up(link_up), .conn_start(conn_start), .data_valid(data_valid), .data_pkt(data_pkt),
    .conn_valid(conn_valid), .conn_cal(conn_cal), .cal_wr(cal_wr), .cal_out(cal_out),
    .gsel_wr(gsel_wr), .gsel_out(gsel_out), .chan_force(chan_force), .chan_num(chan_num),
    .dbg_en(dbg_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata));
  aci_host_model u_host (.core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string what, logic [95:0] seen, logic [95:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  // A value is its high byte, followed by the low byte only in wide mode.
  function automatic void pv(logic [15:0] v);
    exp.push_back(v[15:8]);
    if (ext) exp.push_back(v[7:0]);
  endfunction
  function automatic void axes();
    exp.push_back(aci_pkg::CH_X);
    pv(pkt.x);
    exp.push_back(aci_pkg::CH_Y);
    pv(pkt.y);
    exp.push_back(aci_pkg::CH_Z);
    pv(pkt.z);
  endfunction
  // Offer one byte and hold it until the edge that takes it.
  task automatic cmd(logic [7:0] b);
    int t;
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    t = 0;
    do begin
      @(negedge core_clk);
      t++;
    end while (!rx_ready && t < 400);
    if (t == 400) begin
      err_total++;
      summarize();
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask
  // Wait for the reply to finish, then compare it byte by byte.
  task automatic reply(string what);
    int t;
    for (t = 0; t < 400 && (u_host.got.size() < exp.size() || !rx_ready); t++)
      @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    if (t == 400) begin
      err_total++;
      summarize();
    end
    chk({what, " length"}, 96'(u_host.got.size()), 96'(exp.size()));
    foreach (exp[i]) if (i < u_host.got.size()) chk(what, u_host.got[i], exp[i]);
    exp.delete();
    u_host.got.delete();
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] want);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    @(negedge core_clk);
    chk("register read", reg_rdata, want);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask
  task automatic conn();
    @(posedge core_clk);
    conn_start <= 1'b1;
    @(posedge core_clk);
    conn_start <= 1'b0;
    @(negedge core_clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      pkt = 84'({rnd(), rnd(), rnd()});
      cal = {rnd(), rnd(), rnd()};
      @(posedge core_clk);
      data_valid <= 1'b1;
      data_pkt <= pkt;
      conn_valid <= 1'b1;
      conn_cal <= cal;
      @(posedge core_clk);
      data_valid <= 1'b0;
      conn_valid <= 1'b0;
      if (m == 1) begin
        cmd(aci_pkg::CMD_HS_EXT);
        exp.push_back(aci_pkg::CH_Z_UP);
        reply("wide handshake");
        ext = 1'b1;
      end
      cmd(aci_pkg::CMD_VALUES);
      axes();
      reply("axes");
      cmd(aci_pkg::CMD_VALUES_EXT);
      axes();
      exp.push_back(aci_pkg::CH_S);
      exp.push_back({6'h00, pkt.buttons});
      exp.push_back(aci_pkg::CH_T);
      pv(pkt.temp);
      exp.push_back(aci_pkg::CH_B);
      pv(pkt.bgap);
      reply("full values");
      cmd(aci_pkg::CMD_CAL_READ);
      for (int a = 0; a < 3; a++) begin
        exp.push_back(aci_pkg::CH_X_UP + 8'(a));
        pv(cal[2 * a]);
        pv(cal[2 * a + 1]);
      end
      reply("calibration");
      cmd(aci_pkg::CMD_GSEL_READ);
      exp.push_back(aci_pkg::CH_0 + {6'h00, pkt.grange});
      reply("range");
      d = 2'(rnd());
      cmd(aci_pkg::CMD_GSEL_WRITE);
      cmd(aci_pkg::CH_0 + {6'h00, d});
      reply("range set");
      chk("range out", gsel_out, d);
      chk("range pulses", ngs, m + 1);
      cmd(aci_pkg::CMD_GSEL_READ);
      exp.push_back(aci_pkg::CH_0 + {6'h00, d});
      reply("range back");
      kw = {rnd(), rnd(), rnd()};
      cmd(aci_pkg::CMD_CAL_WRITE);
      for (int i = 0; i < 6; i++) begin
        cmd(kw[i][15:8]);
        if (ext) cmd(kw[i][7:0]);
        ek[i] = ext ? kw[i] : {kw[i][15:8], 8'h00};
      end
      reply("cal write");
      chk("cal out", cal_out, ek);
      chk("cal pulses", ncal, m + 1);
    end
    cmd(aci_pkg::CMD_HS_BASIC);
    exp.push_back(aci_pkg::CH_N);
    reply("handshake");
    ext = 1'b0;
    cmd(aci_pkg::CMD_DBG_ON);
    reply("debug on");
    chk("debug on", dbg_en, 1'b1);
    cmd(aci_pkg::CMD_DBG_OFF);
    reply("debug off");
    chk("debug off", dbg_en, 1'b0);
    cmd(aci_pkg::CMD_DBG_ON);
    cmd(aci_pkg::CMD_HS_BASIC);
    exp.push_back(aci_pkg::CH_N);
    reply("handshake again");
    chk("debug cleared", dbg_en, 1'b0);
    cmd(aci_pkg::CMD_VALUES);
    axes();
    reply("basic after wide");
    @(posedge core_clk) link_up <= 1'b1;
    foreach (leg[i]) begin
      cmd(leg[i]);
      reply("legacy");
    end
    cmd(8'h21);
    reply("unknown");
    conn();
    chk("no force", chan_force, 1'b0);
    @(posedge core_clk) link_up <= 1'b0;
    cmd("7");
    cmd("F");
    reply("channel");
    chk("force pending", chan_force, 1'b0);
    conn();
    chk("force on", chan_force, 1'b1);
    chk("channel", chan_num, 4'hf);
    cmd(aci_pkg::CMD_DBG_ON);
    @(posedge core_clk) link_up <= 1'b1;
    exp.push_back(aci_pkg::CH_C);
    exp.push_back(aci_pkg::CH_F_UP);
    reply("debug line");
    cmd(aci_pkg::CMD_DBG_OFF);
    cmd("3");
    conn();
    chk("channel kept", {chan_force, chan_num}, 5'h1f);
    for (int q = 0; q < 4; q++) begin
      cmd(aci_pkg::CMD_SELF_CAL);
      reply("self cal");
      chk("self cal pulses", ncal, 2 + q / 3);
    end
    chk("self cal data", cal_out, {pkt.z, pkt.z, pkt.y, pkt.y, pkt.x, pkt.x});
    cmd(aci_pkg::CMD_INFO);
    for (int i = aci_pkg::INFO_LEN - 1; i >= 0; i--) exp.push_back(aci_pkg::INFO_TEXT[8 * i +: 8]);
    reply("info");
    rd(aci_pkg::REG_STAT, 32'h1ff9 | {15'h0000, d, 15'h0000});
    rd(aci_pkg::REG_CTRL, 32'h1);
    wr(aci_pkg::REG_CTRL, 32'h0);
    cmd(aci_pkg::CMD_VALUES);
    reply("disabled");
    wr(aci_pkg::REG_CTRL, 32'h1);
    rd(4'h8, 32'h0);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("auto channel", chan_force, 1'b0);
    summarize();
  end
endmodule
